// ---- crs_pkg.sv ----
// Constants and types shared by the core register set
package crs_pkg;

  // Direct-space offsets of the core registers
  localparam logic [7:0] SFR_STACK_TOP = 8'h81;
  localparam logic [7:0] SFR_PTR_LO = 8'h82;
  localparam logic [7:0] SFR_PTR_HI = 8'h83;
  localparam logic [7:0] SFR_PTR1_LO = 8'h84;
  localparam logic [7:0] SFR_PTR1_HI = 8'h85;
  localparam logic [7:0] SFR_ARITH_MODE = 8'h86;
  localparam logic [7:0] SFR_STATUS = 8'hd0;
  localparam logic [7:0] SFR_WORK = 8'he0;
  localparam logic [7:0] SFR_SECOND = 8'hf0;
  localparam logic [7:0] SFR_EXTENSION = 8'hf1;
  localparam logic [7:0] SFR_PAGE_SELECT = 8'hf7;

  // Reset values
  localparam logic [7:0] STACK_TOP_RESET = 8'h07;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ARITH_MODE_RESET = 8'h00;
  localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Status word fields
  localparam int ST_CARRY = 7;
  localparam int ST_HALF = 6;
  localparam int ST_BANK_HI = 4;
  localparam int ST_BANK_LO = 3;
  localparam int ST_EXCESS = 2;
  localparam int ST_PARITY = 0;

  // Arithmetic mode control fields; unlisted bits read zero
  localparam int AM_WIDE_DIV = 3;
  localparam int AM_WIDE_PRODUCT = 2;
  localparam int AM_PTR_CHOICE = 0;
  localparam logic [7:0] ARITH_MODE_MASK = 8'h0d;

  // Direct addresses with this bit set reach the special registers
  localparam int DIRECT_SFR_BIT = 7;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_ADD,
    OP_ADDC,
    OP_SUBB,
    OP_MULTIPLY,
    OP_DIV,
    OP_PUSH,
    OP_POP,
    OP_PTR_LOAD,
    OP_PTR_INC,
    OP_XMOV_RI,
    OP_XMOV_PTR,
    OP_WORK_LOAD
  } crs_op_t;

endpackage

// ---- crs_core_regs.sv ----
// Core register set: work/status/stack/pointer registers, mul/div, RAM segments
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// (RQ1) Eight-bit stack index, increments before push write
// (RQ2) Pop reads stack first, then decrements index
// (RQ3) Reset loads stack index with 07H
// (RQ4) Carry flag follows carry or borrow
// (RQ5) Half carry flag follows auxiliary carry
// (RQ6) Bank select maps R0-R7 into RAM
// (RQ7) Signed excess flag follows overflow
// (RQ8) Status bit 0 is read-only odd parity
// (RQ9) Pointers usable as 16 bits or bytes
// (RQ10) Multiply and divide narrow after every reset
// (RQ11) Narrow multiply: low work, high second
// (RQ12) Wide multiply spreads result over three registers
// (RQ13) Narrow divide: quotient work, remainder second
// (RQ14) Wide divide: quotient high into extension
// (RQ15) Second and extension registers otherwise scratch
// (RQ16) Pointer choice bit selects active pointer
// (RQ17) Lower RAM reachable directly and indirectly
// (RQ18) Upper RAM reachable only indirectly
// (RQ19) Special registers only direct; mode chooses target
// (RQ20) Ri moves reach one 256-byte page, pointer moves 64K
// (RQ21) Page register supplies Ri high byte, resets zero
// (RQ22) Unassigned special addresses hold no storage
module crs_core_regs
  import crs_pkg::*;
(
  input wire logic core_clk_in, // System clock, 25 MHz
  input wire logic reset_in, // Synchronous reset, active high
  input wire crs_op_t op_in, // Core operation this cycle
  input wire logic [7:0] operand_in, // Operation byte operand
  input wire logic [15:0] ptr_data_in, // 16-bit pointer load value
  input wire logic mem_rd_in, // Data space read strobe
  input wire logic mem_wr_in, // Data space write strobe
  input wire logic mem_indirect_in, // Access uses indirect mode
  input wire logic mem_bank_in, // Access is working register Rn
  input wire logic [7:0] mem_addr_in, // Data space address or Rn index
  input wire logic [7:0] mem_wdata_in, // Data space write byte
  output logic [7:0] rdata_out, // Read or pop result
  output logic sfr_hit_out, // Last read was direct and hit a core register
  output logic [7:0] work_out, // Work register
  output logic [7:0] status_out, // Status word
  output logic [7:0] stack_top_out, // Stack top index
  output logic [15:0] ptr_out, // Currently selected pointer
  output logic [15:0] xram_addr_out, // External RAM address
  output logic xram_stb_out // External RAM move strobe
);

  typedef struct packed {
    logic [7:0] work;
    logic [7:0] second;
    logic [7:0] ext;
    logic [7:0] stack;
    logic [7:0] status;
    logic [7:0] ptr_lo;
    logic [7:0] ptr_hi;
    logic [7:0] ptr1_lo;
    logic [7:0] ptr1_hi;
    logic [7:0] mode;
    logic [7:0] page;
    logic [7:0] rdata;
    logic hit;
    logic [15:0] xaddr;
    logic xstb;
    logic [15:0] ptr_view;
  } crs_state_t;

  crs_state_t r;
  crs_state_t r_nxt;
  logic [7:0] iram [0:255];
  logic ram_we;
  logic [7:0] ram_wa;
  logic [7:0] ram_wd;
  logic [7:0] mem_ram_addr;
  logic mem_to_sfr;
  logic [15:0] prod_src;
  logic [23:0] product;
  logic [15:0] div_src;
  logic [15:0] quotient;
  logic [15:0] remainder;
  logic [10:0] alu_res;
  logic [8:0] sfr_rd;
  logic [15:0] ptr_sel;
  logic [15:0] ptr_inc;

  // Returns {carry, half carry, excess, result}
  function automatic logic [10:0] add_sub(input logic [7:0] lhs, input logic [7:0] rhs,
                                          input logic cin, input logic sub);
    logic [8:0] full;
    logic [4:0] half;
    logic excess;
    full = 9'h000;
    half = 5'h00;
    if (sub) begin
      full = {1'b0, lhs} - {1'b0, rhs} - {8'h00, cin};
      half = {1'b0, lhs[3:0]} - {1'b0, rhs[3:0]} - {4'h0, cin};
      excess = (lhs[7] ^ rhs[7]) & (lhs[7] ^ full[7]);
    end else begin
      full = {1'b0, lhs} + {1'b0, rhs} + {8'h00, cin};
      half = {1'b0, lhs[3:0]} + {1'b0, rhs[3:0]} + {4'h0, cin};
      excess = ~(lhs[7] ^ rhs[7]) & (lhs[7] ^ full[7]);
    end
    return {full[8], half[4], excess, full[7:0]};
  endfunction

  // Returns {hit, data}; unassigned addresses miss and read zero
  function automatic logic [8:0] sfr_read(input crs_state_t s, input logic [7:0] a);
    if (a == SFR_STACK_TOP) begin
      return {1'b1, s.stack};
    end else if (a == SFR_PTR_LO) begin
      return {1'b1, s.ptr_lo};
    end else if (a == SFR_PTR_HI) begin
      return {1'b1, s.ptr_hi};
    end else if (a == SFR_PTR1_LO) begin
      return {1'b1, s.ptr1_lo};
    end else if (a == SFR_PTR1_HI) begin
      return {1'b1, s.ptr1_hi};
    end else if (a == SFR_ARITH_MODE) begin
      return {1'b1, s.mode & ARITH_MODE_MASK};
    end else if (a == SFR_STATUS) begin
      return {1'b1, s.status};
    end else if (a == SFR_WORK) begin
      return {1'b1, s.work};
    end else if (a == SFR_SECOND) begin
      return {1'b1, s.second};
    end else if (a == SFR_EXTENSION) begin
      return {1'b1, s.ext};
    end else if (a == SFR_PAGE_SELECT) begin
      return {1'b1, s.page};
    end else begin
      return 9'h000; // RQ22
    end
  endfunction

  // Pointer choice bit picks which pointer every pointer operation uses
  function automatic logic [15:0] select_ptr(input crs_state_t s);
    return s.mode[AM_PTR_CHOICE] ? {s.ptr1_hi, s.ptr1_lo} : {s.ptr_hi, s.ptr_lo}; // RQ16
  endfunction

  // Bank select relocates Rn; direct above 7FH goes to special registers
  assign mem_ram_addr = mem_bank_in ?
      {3'b000, r.status[ST_BANK_HI:ST_BANK_LO], mem_addr_in[2:0]} : mem_addr_in; // RQ6
  assign mem_to_sfr = !mem_indirect_in && !mem_bank_in
      && mem_addr_in[DIRECT_SFR_BIT]; // RQ17 RQ18 RQ19
  assign ptr_sel = select_ptr(r); // RQ16
  assign ptr_inc = ptr_sel + 16'h0001;
  assign prod_src = r.mode[AM_WIDE_PRODUCT] ? {r.ext, r.work} : {8'h00, r.work};
  assign product = {8'h00, prod_src} * {16'h0000, r.second};
  assign div_src = r.mode[AM_WIDE_DIV] ? {r.ext, r.work} : {8'h00, r.work};
  // Divide by zero is caught before use, so the quotient value there is a don't-care
  assign quotient = (r.second == 8'h00) ? 16'h0000 : div_src / {8'h00, r.second};
  assign remainder = (r.second == 8'h00) ? 16'h0000 : div_src % {8'h00, r.second};
  assign alu_res = add_sub(r.work, operand_in, (op_in != OP_ADD) && r.status[ST_CARRY],
                           op_in == OP_SUBB);
  assign sfr_rd = sfr_read(r, mem_addr_in);

  always_comb begin
    r_nxt = r;
    r_nxt.xstb = 1'b0;
    ram_we = 1'b0;
    ram_wa = 8'h00;
    ram_wd = 8'h00;
    case (op_in)
      OP_ADD, OP_ADDC, OP_SUBB: begin
        r_nxt.work = alu_res[7:0];
        r_nxt.status[ST_CARRY] = alu_res[10]; // RQ4
        r_nxt.status[ST_HALF] = alu_res[9]; // RQ5
        r_nxt.status[ST_EXCESS] = alu_res[8]; // RQ7
      end
      OP_MULTIPLY: begin
        r_nxt.work = product[7:0]; // RQ11
        r_nxt.second = product[15:8]; // RQ11 RQ12
        r_nxt.status[ST_CARRY] = 1'b0;
        if (r.mode[AM_WIDE_PRODUCT]) begin
          r_nxt.ext = product[23:16]; // RQ12
          r_nxt.status[ST_EXCESS] = (product[23:8] != 16'h0000);
        end else begin
          r_nxt.status[ST_EXCESS] = (product[15:8] != 8'h00);
        end
      end
      OP_DIV: begin
        r_nxt.status[ST_CARRY] = 1'b0;
        // Division by zero flags excess and leaves operands untouched
        if (r.second == 8'h00) begin
          r_nxt.status[ST_EXCESS] = 1'b1;
        end else begin
          r_nxt.status[ST_EXCESS] = 1'b0;
          r_nxt.work = quotient[7:0]; // RQ13 RQ14
          r_nxt.second = remainder[7:0]; // RQ13 RQ14
          if (r.mode[AM_WIDE_DIV]) begin
            r_nxt.ext = quotient[15:8]; // RQ14
          end
        end
      end
      OP_PUSH: begin
        r_nxt.stack = r.stack + 8'h01; // RQ1
        ram_we = 1'b1;
        ram_wa = r.stack + 8'h01; // RQ1
        ram_wd = operand_in;
      end
      OP_POP: begin
        r_nxt.rdata = iram[r.stack]; // RQ2
        r_nxt.stack = r.stack - 8'h01; // RQ2
      end
      OP_PTR_LOAD: begin
        if (r.mode[AM_PTR_CHOICE]) begin
          {r_nxt.ptr1_hi, r_nxt.ptr1_lo} = ptr_data_in; // RQ9 RQ16
        end else begin
          {r_nxt.ptr_hi, r_nxt.ptr_lo} = ptr_data_in; // RQ9 RQ16
        end
      end
      OP_PTR_INC: begin
        if (r.mode[AM_PTR_CHOICE]) begin
          {r_nxt.ptr1_hi, r_nxt.ptr1_lo} = ptr_inc; // RQ16
        end else begin
          {r_nxt.ptr_hi, r_nxt.ptr_lo} = ptr_inc; // RQ16
        end
      end
      OP_XMOV_RI: begin
        r_nxt.xaddr = {r.page, operand_in}; // RQ20 RQ21
        r_nxt.xstb = 1'b1;
      end
      OP_XMOV_PTR: begin
        r_nxt.xaddr = ptr_sel; // RQ20 RQ16
        r_nxt.xstb = 1'b1;
      end
      OP_WORK_LOAD: begin
        r_nxt.work = operand_in;
      end
      default: begin
      end
    endcase
    // Data space access; a write here overrides an operation in the same cycle
    if (mem_rd_in) begin
      if (mem_to_sfr) begin
        r_nxt.rdata = sfr_rd[7:0]; // RQ19 RQ22
        r_nxt.hit = sfr_rd[8];
      end else begin
        r_nxt.rdata = iram[mem_ram_addr]; // RQ17 RQ18
        r_nxt.hit = 1'b0;
      end
    end
    if (mem_wr_in) begin
      if (!mem_to_sfr) begin
        ram_we = 1'b1;
        ram_wa = mem_ram_addr; // RQ17 RQ18 RQ6
        ram_wd = mem_wdata_in;
      end else if (mem_addr_in == SFR_STACK_TOP) begin
        r_nxt.stack = mem_wdata_in;
      end else if (mem_addr_in == SFR_PTR_LO) begin
        r_nxt.ptr_lo = mem_wdata_in; // RQ9
      end else if (mem_addr_in == SFR_PTR_HI) begin
        r_nxt.ptr_hi = mem_wdata_in; // RQ9
      end else if (mem_addr_in == SFR_PTR1_LO) begin
        r_nxt.ptr1_lo = mem_wdata_in; // RQ9
      end else if (mem_addr_in == SFR_PTR1_HI) begin
        r_nxt.ptr1_hi = mem_wdata_in; // RQ9
      end else if (mem_addr_in == SFR_ARITH_MODE) begin
        r_nxt.mode = mem_wdata_in & ARITH_MODE_MASK;
      end else if (mem_addr_in == SFR_STATUS) begin
        r_nxt.status = mem_wdata_in;
      end else if (mem_addr_in == SFR_WORK) begin
        r_nxt.work = mem_wdata_in;
      end else if (mem_addr_in == SFR_SECOND) begin
        r_nxt.second = mem_wdata_in; // RQ15
      end else if (mem_addr_in == SFR_EXTENSION) begin
        r_nxt.ext = mem_wdata_in; // RQ15
      end else if (mem_addr_in == SFR_PAGE_SELECT) begin
        r_nxt.page = mem_wdata_in; // RQ21
      end
    end
    // Parity always tracks the next work value, so software writes to it are lost
    r_nxt.status[ST_PARITY] = ^r_nxt.work; // RQ8
    // Registered copy of the chosen pointer so the output leaves a flip-flop
    r_nxt.ptr_view = select_ptr(r_nxt); // RQ16
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      r <= '0;
      r.stack <= STACK_TOP_RESET; // RQ3
      r.status <= STATUS_RESET;
      r.mode <= ARITH_MODE_RESET; // RQ10
      r.page <= PAGE_SELECT_RESET; // RQ21
      r.work <= DATA_RESET;
    end else begin
      r <= r_nxt;
    end
  end

  // RAM keeps its contents through reset
  always_ff @(posedge core_clk_in) begin
    if (ram_we) begin
      iram[ram_wa] <= ram_wd;
    end
  end

  assign rdata_out = r.rdata;
  assign sfr_hit_out = r.hit;
  assign work_out = r.work;
  assign status_out = r.status;
  assign stack_top_out = r.stack;
  assign ptr_out = r.ptr_view;
  assign xram_addr_out = r.xaddr;
  assign xram_stb_out = r.xstb;

  logic [7:0] stack_top_byte;
  assign stack_top_byte = iram[r.stack];

  default clocking chk_cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  chk_reset_stack: assert property (disable iff (1'b0) reset_in |=> // RQ3
      stack_top_out == STACK_TOP_RESET && r.mode == 8'h00 && r.page == 8'h00)
    else $error("stack index or mode not reset");
  chk_push_order: assert property (op_in == OP_PUSH && !mem_wr_in |=> // RQ1
      stack_top_out == $past(stack_top_out) + 8'h01 && stack_top_byte == $past(operand_in))
    else $error("push did not pre-increment");
  chk_pop_order: assert property (op_in == OP_POP && !mem_rd_in && !mem_wr_in |=> // RQ2
      rdata_out == $past(stack_top_byte) && stack_top_out == $past(stack_top_out) - 8'h01)
    else $error("pop did not read before decrement");
  chk_parity_live: assert property (status_out[ST_PARITY] == ^work_out) // RQ8
    else $error("parity does not follow work register");
  chk_add_carry: assert property (op_in == OP_ADD && !mem_wr_in |=> // RQ4
      {status_out[ST_CARRY], work_out} == {1'b0, $past(work_out)} + {1'b0, $past(operand_in)})
    else $error("add carry wrong");
  chk_narrow_product: assert property (op_in == OP_MULTIPLY && !r.mode[AM_WIDE_PRODUCT] // RQ11
      && !mem_wr_in |=> {r.second, work_out} == $past(work_out) * $past(r.second))
    else $error("narrow multiply wrong");
  chk_div_wide: assert property (op_in == OP_DIV && r.mode[AM_WIDE_DIV] // RQ14
      && r.second != 8'h00 && !mem_wr_in
      |=> {r.ext, work_out} == $past({r.ext, work_out}) / {8'h00, $past(r.second)})
    else $error("wide divide quotient wrong");
  chk_upper_indirect: assert property (mem_rd_in && mem_indirect_in // RQ18
      && op_in != OP_POP |=> !sfr_hit_out ##1 1'b1)
    else $error("indirect read reached special registers");
  chk_unmapped_sfr: assert property (mem_rd_in && !mem_indirect_in && !mem_bank_in // RQ22
      && mem_addr_in == 8'hc0 |=> !sfr_hit_out && rdata_out == 8'h00)
    else $error("unassigned special address gave data");
  chk_page_addr: assert property (op_in == OP_XMOV_RI |=> // RQ21
      xram_stb_out && xram_addr_out == {$past(r.page), $past(operand_in)})
    else $error("page register not used as high byte");
  chk_div_narrow: assert property (op_in == OP_DIV && !r.mode[AM_WIDE_DIV] // RQ13
      && r.second != 8'h00 && !mem_wr_in
      |=> work_out == $past(work_out) / $past(r.second)
      && r.second == $past(work_out) % $past(r.second) && r.ext == $past(r.ext))
    else $error("narrow divide wrong");
  chk_wide_product: assert property (op_in == OP_MULTIPLY && r.mode[AM_WIDE_PRODUCT] // RQ12
      && !mem_wr_in |=> {r.ext, r.second, work_out}
      == {8'h00, $past({r.ext, work_out})} * {16'h0000, $past(r.second)})
    else $error("wide multiply wrong");
  chk_bank_map: assert property (mem_wr_in && mem_bank_in |-> // RQ6
      ram_we && ram_wa == {3'b000, status_out[ST_BANK_HI:ST_BANK_LO], mem_addr_in[2:0]})
    else $error("working register write missed its bank");
  // Registered pointer view must never lag the choice bit
  chk_ptr_choice: assert property (ptr_out == (r.mode[AM_PTR_CHOICE] ? // RQ16
      {r.ptr1_hi, r.ptr1_lo} : {r.ptr_hi, r.ptr_lo}))
    else $error("pointer output not the chosen pointer");
  chk_ptr_move: assert property (op_in == OP_XMOV_PTR |=> // RQ20
      xram_stb_out && xram_addr_out == $past(ptr_out))
    else $error("pointer move did not use the chosen pointer");
  chk_strobe_pulse: assert property (xram_stb_out && op_in == OP_NONE |=> // RQ20
      !xram_stb_out)
    else $error("external move strobe held too long");

  cov_wide_product: cover property (op_in == OP_MULTIPLY && r.mode[AM_WIDE_PRODUCT]);
  cov_push_pop: cover property (op_in == OP_PUSH ##1 op_in == OP_POP);
  cov_second_ptr: cover property (op_in == OP_XMOV_PTR && r.mode[AM_PTR_CHOICE]);
  cov_div_zero: cover property (op_in == OP_DIV && r.second == 8'h00);
  cov_bank_three: cover property (mem_wr_in && mem_bank_in
      && r.status[ST_BANK_HI:ST_BANK_LO] == 2'b11);

endmodule

`default_nettype wire

// ---- crs_core_regs_tb_top.sv ----
// Self-checking testbench for the core register set
`timescale 1ns/100ps
`default_nettype none
module crs_core_regs_tb_top
  import crs_pkg::*;
();
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  crs_op_t op_in = OP_NONE;
  logic [7:0] operand_in = 8'h00;
  logic [15:0] ptr_data_in = 16'h0000;
  logic mem_rd_in = 1'b0;
  logic mem_wr_in = 1'b0;
  logic mem_indirect_in = 1'b0;
  logic mem_bank_in = 1'b0;
  logic [7:0] mem_addr_in = 8'h00;
  logic [7:0] mem_wdata_in = 8'h00;
  logic [7:0] rdata_out;
  logic sfr_hit_out;
  logic [7:0] work_out;
  logic [7:0] status_out;
  logic [7:0] stack_top_out;
  logic [15:0] ptr_out;
  logic [15:0] xram_addr_out;
  logic xram_stb_out;
  int fail_count = 0;
  int tests_run = 0;

  always #20 core_clk_in = ~core_clk_in;

  crs_core_regs dut_u (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .op_in(op_in),
    .operand_in(operand_in), .ptr_data_in(ptr_data_in), .mem_rd_in(mem_rd_in),
    .mem_wr_in(mem_wr_in), .mem_indirect_in(mem_indirect_in),
    .mem_bank_in(mem_bank_in), .mem_addr_in(mem_addr_in),
    .mem_wdata_in(mem_wdata_in), .rdata_out(rdata_out), .sfr_hit_out(sfr_hit_out),
    .work_out(work_out), .status_out(status_out), .stack_top_out(stack_top_out),
    .ptr_out(ptr_out), .xram_addr_out(xram_addr_out), .xram_stb_out(xram_stb_out)
  );

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle data space request, launched and released at falling edges
  task automatic data_req(input logic r, input logic w, input logic ind, input logic bk,
                     input logic [7:0] a, input logic [7:0] d);
    mem_rd_in = r;
    mem_wr_in = w;
    mem_indirect_in = ind;
    mem_bank_in = bk;
    mem_addr_in = a;
    mem_wdata_in = d;
    @(negedge core_clk_in);
    mem_rd_in = 1'b0;
    mem_wr_in = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    data_req(1'b0, 1'b1, 1'b0, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic ind);
    data_req(1'b1, 1'b0, ind, 1'b0, a, 8'h00);
  endtask

  task automatic do_op(input crs_op_t o, input logic [7:0] v);
    op_in = o;
    operand_in = v;
    @(negedge core_clk_in);
    op_in = OP_NONE;
  endtask

  // Cuts a hang short; the whole sequence needs about 100 cycles
  initial begin
    repeat (3000) @(posedge core_clk_in);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (3) @(negedge core_clk_in);
    reset_in = 1'b0;
    chk(stack_top_out, 16'h0007);
    chk(status_out, 16'h0000);
    rd(SFR_ARITH_MODE, 1'b0);
    chk(rdata_out, 16'h0000);
    rd(SFR_PAGE_SELECT, 1'b0);
    chk(rdata_out, 16'h0000);
    rd(SFR_STACK_TOP, 1'b0);
    chk({sfr_hit_out, rdata_out}, 16'h0107);
    // Stack: first push lands at 08H, pops read before stepping back
    do_op(OP_PUSH, 8'ha5);
    chk(stack_top_out, 16'h0008);
    do_op(OP_PUSH, 8'h5a);
    rd(8'h08, 1'b1);
    chk(rdata_out, 16'h00a5);
    do_op(OP_POP, 8'h00);
    chk({stack_top_out, rdata_out}, 16'h085a);
    do_op(OP_POP, 8'h00);
    chk({stack_top_out, rdata_out}, 16'h07a5);
    // Parity follows the work register and ignores writes
    do_op(OP_WORK_LOAD, 8'h07);
    chk(status_out[0], 16'h0001);
    do_op(OP_WORK_LOAD, 8'h03);
    wr(SFR_STATUS, 8'hff);
    rd(SFR_STATUS, 1'b0);
    chk(rdata_out, 16'h00fe);
    wr(SFR_STATUS, 8'h00);
    // Flags from adds and subtracts
    do_op(OP_WORK_LOAD, 8'hff);
    do_op(OP_ADD, 8'h01);
    chk({work_out, status_out}, 16'h00c0);
    do_op(OP_WORK_LOAD, 8'h7f);
    do_op(OP_ADD, 8'h01);
    chk({work_out, status_out}, 16'h8045);
    do_op(OP_WORK_LOAD, 8'h01);
    do_op(OP_ADD, 8'h01);
    chk({work_out, status_out}, 16'h0201);
    do_op(OP_WORK_LOAD, 8'h00);
    do_op(OP_SUBB, 8'h01);
    chk({work_out, status_out}, 16'hffc0);
    // Add with carry takes the stored carry in
    do_op(OP_ADDC, 8'h00);
    chk({work_out, status_out}, 16'h00c0);
    do_op(OP_ADDC, 8'h10);
    chk({work_out, status_out}, 16'h1100);
    // Every bank maps R2 to its own RAM byte
    for (int bank = 0; bank < 4; bank++) begin
      wr(SFR_STATUS, 8'(bank << 3));
      data_req(1'b0, 1'b1, 1'b0, 1'b1, 8'h02, 8'h40 + 8'(bank));
      rd(8'(bank * 8 + 2), 1'b1);
      chk(rdata_out, 16'h0040 + 16'(bank));
    end
    wr(SFR_STATUS, 8'h00);
    // Narrow and wide multiply and divide
    do_op(OP_WORK_LOAD, 8'hc8);
    wr(SFR_SECOND, 8'h0a);
    do_op(OP_MULTIPLY, 8'h00);
    rd(SFR_SECOND, 1'b0);
    chk({rdata_out, work_out}, 16'h07d0);
    wr(SFR_ARITH_MODE, 8'hff);
    rd(SFR_ARITH_MODE, 1'b0);
    chk(rdata_out, 16'h000d);
    wr(SFR_ARITH_MODE, 8'h04);
    wr(SFR_EXTENSION, 8'h12);
    wr(SFR_SECOND, 8'h56);
    do_op(OP_WORK_LOAD, 8'h34);
    do_op(OP_MULTIPLY, 8'h00);
    rd(SFR_SECOND, 1'b0);
    chk({rdata_out, work_out}, 16'h1d78);
    rd(SFR_EXTENSION, 1'b0);
    chk(rdata_out, 16'h0006);
    wr(SFR_ARITH_MODE, 8'h00);
    wr(SFR_SECOND, 8'h0b);
    do_op(OP_WORK_LOAD, 8'hd0);
    do_op(OP_DIV, 8'h00);
    rd(SFR_SECOND, 1'b0);
    chk({rdata_out, work_out}, 16'h0a12);
    wr(SFR_ARITH_MODE, 8'h08);
    wr(SFR_EXTENSION, 8'h12);
    wr(SFR_SECOND, 8'h10);
    do_op(OP_WORK_LOAD, 8'h34);
    do_op(OP_DIV, 8'h00);
    rd(SFR_EXTENSION, 1'b0);
    chk({rdata_out, work_out}, 16'h0123);
    rd(SFR_SECOND, 1'b0);
    chk(rdata_out, 16'h0004);
    // Zero divisor leaves the operands alone
    wr(SFR_SECOND, 8'h00);
    do_op(OP_DIV, 8'h00);
    chk({work_out, status_out[7], status_out[2]}, {6'h00, 8'h23, 2'b01});
    wr(SFR_EXTENSION, 8'ha5);
    rd(SFR_EXTENSION, 1'b0);
    chk(rdata_out, 16'h00a5);
    // Dual pointers, byte writes and selection
    wr(SFR_PTR_LO, 8'h11);
    wr(SFR_PTR_HI, 8'h22);
    wr(SFR_PTR1_LO, 8'h33);
    wr(SFR_PTR1_HI, 8'h44);
    wr(SFR_ARITH_MODE, 8'h00);
    chk(ptr_out, 16'h2211);
    wr(SFR_ARITH_MODE, 8'h01);
    chk(ptr_out, 16'h4433);
    ptr_data_in = 16'habcd;
    do_op(OP_PTR_LOAD, 8'h00);
    rd(SFR_PTR1_LO, 1'b0);
    chk(rdata_out, 16'h00cd);
    do_op(OP_PTR_INC, 8'h00);
    do_op(OP_XMOV_PTR, 8'h00);
    chk({xram_stb_out, xram_addr_out[7:0]}, 16'h01ce);
    chk(xram_addr_out, 16'habce);
    @(negedge core_clk_in);
    chk(xram_stb_out, 16'h0000);
    wr(SFR_PAGE_SELECT, 8'h01);
    do_op(OP_XMOV_RI, 8'h80);
    chk(xram_addr_out, 16'h0180);
    // Lower RAM both ways, upper RAM only indirect, core registers only direct
    wr(8'h40, 8'h77);
    rd(8'h40, 1'b1);
    chk(rdata_out, 16'h0077);
    data_req(1'b0, 1'b1, 1'b1, 1'b0, 8'he0, 8'h66);
    wr(SFR_WORK, 8'h55);
    rd(8'he0, 1'b1);
    chk(rdata_out, 16'h0066);
    rd(SFR_WORK, 1'b0);
    chk({sfr_hit_out, rdata_out}, 16'h0155);
    data_req(1'b0, 1'b1, 1'b1, 1'b0, 8'hc0, 8'h99);
    wr(8'hc0, 8'hff);
    rd(8'hc0, 1'b0);
    chk({sfr_hit_out, rdata_out}, 16'h0000);
    rd(8'hc0, 1'b1);
    chk(rdata_out, 16'h0099);
    // Second reset in mid-run brings back narrow mode and the stack base
    reset_in = 1'b1;
    @(negedge core_clk_in);
    reset_in = 1'b0;
    chk(stack_top_out, 16'h0007);
    rd(SFR_ARITH_MODE, 1'b0);
    chk(rdata_out, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
